/* src/cbcr_pkg.sv */
// constants shared by the card bridge configuration register group
package cbcr_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // printed register offsets, kept as word indices
  localparam logic [9:0] IDX_DMA_WIN  = 10'h098;
  localparam logic [9:0] IDX_PREFETCH = 10'h09C;
  localparam logic [9:0] IDX_SYSERR   = 10'h09F;

  // byte addresses on the bus are four times the index
  localparam logic [ADDR_W-1:0] ADR_DMA_WIN  = {IDX_DMA_WIN, 2'b00};
  localparam logic [ADDR_W-1:0] ADR_PREFETCH = {IDX_PREFETCH, 2'b00};
  localparam logic [ADDR_W-1:0] ADR_SYSERR   = {IDX_SYSERR, 2'b00};

  // field positions of the dma window register
  localparam int unsigned DMA_BASE_LSB = 4;
  localparam int unsigned DMA_BASE_MSB = 15;
  localparam int unsigned DMA_XFER_LSB = 1;
  localparam int unsigned DMA_XFER_MSB = 2;
  localparam int unsigned DMA_DEC_BIT  = 0;

  // field positions of the prefetch and error mask registers
  localparam int unsigned PREF_OFF_BIT = 4;
  localparam int unsigned MASK_MAB_BIT = 4;
  localparam int unsigned MASK_TAB_BIT = 3;
  localparam int unsigned MASK_PAR_BIT = 2;

  // reset values
  localparam logic [31:0] DMA_WIN_RST  = 32'h0000_0000;
  localparam logic [7:0]  PREFETCH_RST = 8'h00;
  localparam logic [7:0]  SYSERR_RST   = 8'h00;

  // writable bits; everything else is reserved and reads zero
  localparam logic [31:0] DMA_WIN_WMASK  = 32'h0000_FFF7;
  localparam logic [7:0]  PREFETCH_WMASK = 8'h10;
  localparam logic [7:0]  SYSERR_WMASK   = 8'h1C;

  localparam int unsigned IO_ADDR_W = 16;

endpackage

/* src/cbcr_dma_decode.sv */
// registered decoder for the dma register window in i/o space
`timescale 1ns/1ps
module cbcr_dma_decode (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [15:0] io_addr,
  input  wire logic        io_cycle,
  input  wire logic [11:0] base,
  input  wire logic        decode_on,
  output logic             hit
);
  import cbcr_pkg::*;

  logic next_hit;

  // the window spans sixteen bytes, so only the upper address bits compare
  always_comb begin
    next_hit = io_cycle && decode_on && (io_addr[15:4] == base);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hit <= 1'b0;
    end else begin
      hit <= next_hit;
    end
  end

endmodule

/* src/cbcr_syserr_gate.sv */
// gates posted-write and card-side fault events onto the system error line
`timescale 1ns/1ps
module cbcr_syserr_gate (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pw_master_abort,
  input  wire logic pw_target_abort,
  input  wire logic pw_parity_err,
  input  wire logic card_parity_err,
  input  wire logic mask_mab,
  input  wire logic mask_tab,
  input  wire logic mask_par,
  output logic      syserr_n
);
  import cbcr_pkg::*;

  logic next_syserr_n;

  always_comb begin
    next_syserr_n = 1'b1;
    if (pw_master_abort && !mask_mab) begin
      next_syserr_n = 1'b0;
    end
    if (pw_target_abort && !mask_tab) begin
      next_syserr_n = 1'b0;
    end
    // card-side parity faults obey the same mask on any transaction
    if ((pw_parity_err || card_parity_err) && !mask_par) begin
      next_syserr_n = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      syserr_n <= 1'b1;
    end else begin
      syserr_n <= next_syserr_n;
    end
  end

endmodule

/* src/cbcr_top.sv */
// card bridge configuration registers behind an apb slave
//
// Notes on behaviour
// - reserved bits read as zero; software writes zero to them
// - bits 15:4 of dma window register hold the i/o base address
// - bits 2:1 of dma window register select 16-bit card transfer size
// - bit 0 enables window decoding; cleared means no decode
// - chip control bit 4 set turns card prefetch reads off
// - posted-write master abort raises system error unless mask bit 4
// - posted-write target abort raises system error unless mask bit 3
// - posted-write parity error raises system error unless mask bit 2
// - mask bit 2 also gates card-side parity errors on any cycle
`timescale 1ns/1ps
module cbcr_top (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [cbcr_pkg::ADDR_W-1:0] paddr,
  input  wire logic [cbcr_pkg::DATA_W-1:0] pwdata,
  input  wire logic [3:0]                pstrb,
  output logic      [cbcr_pkg::DATA_W-1:0] prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic [15:0]               io_addr,
  input  wire logic                      io_cycle,
  input  wire logic                      pw_master_abort,
  input  wire logic                      pw_target_abort,
  input  wire logic                      pw_parity_err,
  input  wire logic                      card_parity_err,
  output logic                           dma_window_hit,
  output logic                           syserr_n,
  output logic      [11:0]               dma_io_base,
  output logic      [1:0]                dma_xfer_width,
  output logic                           dma_window_decode_on,
  output logic                           prefetch_off
);
  import cbcr_pkg::*;

  logic [31:0] dma_win;
  logic [7:0]  pref_ctl;
  logic [7:0]  err_mask;
  logic [31:0] next_dma_win;
  logic [7:0]  next_pref_ctl;
  logic [7:0]  next_err_mask;

  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;

  logic        access;
  logic        wr_go;
  logic [31:0] lane_mask;
  logic [31:0] pref_merged;
  logic [31:0] err_merged;

  // widen byte strobes into a bit mask
  function automatic logic [31:0] strb_bits(input logic [3:0] s);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[8*i +: 8] = {8{s[i]}};
    end
    return m;
  endfunction

  // true when the address names a mapped register
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return (a == ADR_DMA_WIN) || (a == ADR_PREFETCH) || (a == ADR_SYSERR);
  endfunction

  // merge write data into a register through its writable-bit mask
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [31:0] wm);
    return (old & ~wm) | (wd & wm);
  endfunction

  // ---------------------------------------------------------------------
  // apb handshake: one wait state, so pready rises on the second access
  // cycle; a registered answer keeps prdata and pready off combinational
  // paths from paddr
  // ---------------------------------------------------------------------
  always_comb begin
    access       = psel && penable && !pready;
    next_pready  = access;
    next_pslverr = access && !is_mapped(paddr);
    next_prdata  = 32'h0000_0000;
    if (access && !pwrite) begin
      unique case (paddr)
        ADR_DMA_WIN:  next_prdata = dma_win;
        ADR_PREFETCH: next_prdata = {24'h00_0000, pref_ctl};
        ADR_SYSERR:   next_prdata = {24'h00_0000, err_mask};
        default:      next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= next_pready;
      pslverr <= next_pslverr;
      prdata  <= next_prdata;
    end
  end

  // ---------------------------------------------------------------------
  // register file; a write lands on the edge that completes the access
  // ---------------------------------------------------------------------
  always_comb begin
    wr_go         = psel && penable && pready && pwrite;
    lane_mask     = strb_bits(pstrb);
    // byte registers merge as whole words and then keep their low byte
    pref_merged   = merge({24'h00_0000, pref_ctl}, pwdata,
                          {24'h00_0000, PREFETCH_WMASK} & lane_mask);
    err_merged    = merge({24'h00_0000, err_mask}, pwdata,
                          {24'h00_0000, SYSERR_WMASK} & lane_mask);
    next_dma_win  = dma_win;
    next_pref_ctl = pref_ctl;
    next_err_mask = err_mask;
    if (wr_go) begin
      // reserved and read-only bits keep their value
      if (paddr == ADR_DMA_WIN) begin
        next_dma_win = merge(dma_win, pwdata,
                             DMA_WIN_WMASK & lane_mask);
      end
      if (paddr == ADR_PREFETCH) begin
        next_pref_ctl = pref_merged[7:0];
      end
      if (paddr == ADR_SYSERR) begin
        next_err_mask = err_merged[7:0];
      end
    end
  end

  // all implemented bits clear on reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_win  <= DMA_WIN_RST;
      pref_ctl <= PREFETCH_RST;
      err_mask <= SYSERR_RST;
    end else begin
      dma_win  <= next_dma_win;
      pref_ctl <= next_pref_ctl;
      err_mask <= next_err_mask;
    end
  end

  // configuration outputs are register slices, hence flop-driven
  always_comb begin
    dma_io_base          = dma_win[DMA_BASE_MSB:DMA_BASE_LSB];
    dma_xfer_width       = dma_win[DMA_XFER_MSB:DMA_XFER_LSB];
    dma_window_decode_on = dma_win[DMA_DEC_BIT];
    prefetch_off         = pref_ctl[PREF_OFF_BIT];
  end

  // the card unit has no dma engine; the hit only flags a claimed cycle
  cbcr_dma_decode u_decode (
    .pclk      (pclk),
    .presetn   (presetn),
    .io_addr   (io_addr),
    .io_cycle  (io_cycle),
    .base      (dma_win[DMA_BASE_MSB:DMA_BASE_LSB]),
    .decode_on (dma_win[DMA_DEC_BIT]),
    .hit       (dma_window_hit)
  );

  cbcr_syserr_gate u_syserr (
    .pclk            (pclk),
    .presetn         (presetn),
    .pw_master_abort (pw_master_abort),
    .pw_target_abort (pw_target_abort),
    .pw_parity_err   (pw_parity_err),
    .card_parity_err (card_parity_err),
    .mask_mab        (err_mask[MASK_MAB_BIT]),
    .mask_tab        (err_mask[MASK_TAB_BIT]),
    .mask_par        (err_mask[MASK_PAR_BIT]),
    .syserr_n        (syserr_n)
  );

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_wait;
    psel && penable && !pready;
  endsequence

  sequence s_write_to(logic [ADDR_W-1:0] a);
    psel && penable && pready && pwrite && (paddr == a);
  endsequence

  // first access cycle of a read; the answer stands one cycle later
  sequence s_read_at(logic [ADDR_W-1:0] a);
    s_wait ##0 !pwrite ##0 (paddr == a);
  endsequence

  a_apb_answer:
    assert property (s_wait |=> pready ##1 !pready)
    else $error("apb answer not one wait state");

  a_reserved_zero:
    assert property (dma_win[31:16] == 16'h0000 && !dma_win[3]
                     && (pref_ctl & ~PREFETCH_WMASK) == 8'h00
                     && (err_mask & ~SYSERR_WMASK) == 8'h00)
    else $error("reserved bit holds a one");

  a_base_write:
    assert property (s_write_to(ADR_DMA_WIN) ##0 (pstrb[1:0] == 2'b11)
                     |=> dma_io_base == $past(pwdata[15:4]))
    else $error("dma base not written");

  a_xfer_write:
    assert property (s_write_to(ADR_DMA_WIN) ##0 pstrb[0]
                     |=> dma_xfer_width == $past(pwdata[2:1]))
    else $error("transfer size not written");

  a_decode_off:
    assert property (!dma_window_decode_on |=> !dma_window_hit)
    else $error("window decoded while disabled");

  a_decode_hit:
    assert property (io_cycle && dma_window_decode_on
                     && io_addr[15:4] == dma_io_base |=> dma_window_hit)
    else $error("enabled window missed");

  a_prefetch_write:
    assert property (s_write_to(ADR_PREFETCH) ##0 pstrb[0]
                     |=> prefetch_off == $past(pwdata[4]))
    else $error("prefetch control not written");

  a_serr_mab:
    assert property (pw_master_abort && !err_mask[MASK_MAB_BIT]
                     |=> !syserr_n)
    else $error("master abort lost");

  a_serr_tab:
    assert property (pw_target_abort && !err_mask[MASK_TAB_BIT]
                     |=> !syserr_n)
    else $error("target abort lost");

  a_serr_par:
    assert property (pw_parity_err && !err_mask[MASK_PAR_BIT]
                     |=> !syserr_n)
    else $error("posted parity error lost");

  a_serr_card:
    assert property (card_parity_err && !err_mask[MASK_PAR_BIT]
                     |=> !syserr_n)
    else $error("card parity error lost");

  a_serr_quiet:
    assert property (!(pw_master_abort && !err_mask[MASK_MAB_BIT])
                     && !(pw_target_abort && !err_mask[MASK_TAB_BIT])
                     && !((pw_parity_err || card_parity_err)
                          && !err_mask[MASK_PAR_BIT]) |=> syserr_n)
    else $error("system error without unmasked cause");

  a_regs_hold:
    assert property (!(psel && penable && pready && pwrite)
                     |=> $stable(dma_win) && $stable(pref_ctl)
                         && $stable(err_mask))
    else $error("register changed without write");

  a_unmapped_err:
    assert property (s_wait ##0 !is_mapped(paddr) |=> pslverr && pready)
    else $error("unmapped access not flagged");

  a_read_upper:
    assert property (s_wait ##0 !pwrite |=> prdata[31:16] == 16'h0000)
    else $error("reserved read bits not zero");

  a_read_dma:
    assert property (s_read_at(ADR_DMA_WIN) |=> prdata == $past(dma_win))
    else $error("dma window readback wrong");

  a_read_pref:
    assert property (s_read_at(ADR_PREFETCH)
                     |=> prdata == {24'h00_0000, $past(pref_ctl)})
    else $error("prefetch readback wrong");

  a_mask_write:
    assert property (s_write_to(ADR_SYSERR) ##0 pstrb[0]
                     |=> err_mask == ($past(pwdata[7:0]) & SYSERR_WMASK))
    else $error("error mask not written");

  a_lane_keep:
    assert property (s_write_to(ADR_DMA_WIN) ##0 !pstrb[1]
                     |=> dma_io_base[11:4] == $past(dma_io_base[11:4]))
    else $error("unstrobed base byte changed");

  // a write to a hole must not disturb any stored bit
  a_stray_write:
    assert property (psel && penable && pready && pwrite && !is_mapped(paddr)
                     |=> $stable(dma_win) && $stable(pref_ctl)
                         && $stable(err_mask))
    else $error("unmapped write changed a register");

  a_hit_cause:
    assert property (!io_cycle |=> !dma_window_hit)
    else $error("hit without i/o cycle");

endmodule

/* verif/cbcr_host_model.sv */
// apb master standing in for the host bus controller
`timescale 1ns/1ps
module cbcr_host_model (
  input  wire logic                        pclk,
  output logic                             psel,
  output logic                             penable,
  output logic                             pwrite,
  output logic [cbcr_pkg::ADDR_W-1:0]      paddr,
  output logic [cbcr_pkg::DATA_W-1:0]      pwdata,
  output logic [3:0]                       pstrb,
  input  wire logic [cbcr_pkg::DATA_W-1:0] prdata,
  input  wire logic                        pready,
  input  wire logic                        pslverr
);
  import cbcr_pkg::*;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hF;
  end
  // one full transfer; only pready ends it, the bench watchdog ends a hang
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d, input logic [3:0] s,
                      output logic [DATA_W-1:0] rd, output logic err);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    pstrb  <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // released lines must not keep showing the old request
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
endmodule

/* verif/cbcr_top_tb.sv */
// self-checking bench for the card bridge configuration registers
`timescale 1ns/1ps
module cbcr_top_tb;
  import cbcr_pkg::*;
  logic               pclk = 1'b0;
  logic               presetn = 1'b0;
  logic               psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0]  paddr;
  logic [DATA_W-1:0]  pwdata, prdata;
  logic [3:0]         pstrb;
  logic [15:0]        io_addr = '0;
  logic               io_cycle = 1'b0;
  logic [3:0]         evt = '0;
  logic               hit, syserr_n, dec_on, pref_off;
  logic [11:0]        base;
  logic [1:0]         xw;
  int                 err_count = 0;
  int                 comparisons = 0;

  always #2 pclk = ~pclk;

  cbcr_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .io_addr(io_addr), .io_cycle(io_cycle), .pw_master_abort(evt[0]),
    .pw_target_abort(evt[1]), .pw_parity_err(evt[2]),
    .card_parity_err(evt[3]), .dma_window_hit(hit), .syserr_n(syserr_n),
    .dma_io_base(base), .dma_xfer_width(xw),
    .dma_window_decode_on(dec_on), .prefetch_off(pref_off));

  cbcr_host_model host_u (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd(logic [ADDR_W-1:0] a, logic [31:0] exp, string what);
    logic [31:0] d;
    logic        e;
    host_u.xfer(1'b0, a, 32'h0, 4'h0, d, e);
    chk(what, exp, d);
    chk("read error flag", 32'h0, {31'h0, e});
  endtask

  task automatic wr(logic [ADDR_W-1:0] a, logic [31:0] d);
    logic [31:0] r;
    logic        e;
    host_u.xfer(1'b1, a, d, 4'hF, r, e);
    chk("write error flag", 32'h0, {31'h0, e});
  endtask

  // qualifying cycle at one edge, registered hit visible after the next
  task automatic io_try(logic [15:0] a, logic exp);
    @(posedge pclk);
    io_addr  <= a;
    io_cycle <= 1'b1;
    @(posedge pclk);
    io_cycle <= 1'b0;
    #1 chk("window hit", {31'h0, exp}, {31'h0, hit});
  endtask

  task automatic ev(int i, logic exp_n);
    @(posedge pclk);
    evt[i] <= 1'b1;
    @(posedge pclk);
    evt[i] <= 1'b0;
    #1 chk("syserr_n", {31'h0, exp_n}, {31'h0, syserr_n});
  endtask

  task automatic t_reset();
    rd(ADR_DMA_WIN, 32'h0, "dma window");
    rd(ADR_PREFETCH, 32'h0, "prefetch");
    rd(ADR_SYSERR, 32'h0, "error mask");
    $display("test reset done");
  endtask

  task automatic t_dma();
    logic [31:0] d;
    logic        e;
    wr(ADR_DMA_WIN, 32'h0000_FFF7);
    rd(ADR_DMA_WIN, 32'h0000_FFF7, "dma window writable bits");
    chk("base", 32'hFFF, {20'h0, base});
    wr(ADR_DMA_WIN, 32'h0000_ABC5);
    rd(ADR_DMA_WIN, 32'h0000_ABC5, "dma window value");
    chk("xfer width", 32'h2, {30'h0, xw});
    chk("decode on", 32'h1, {31'h0, dec_on});
    io_try(16'hABC7, 1'b1);
    io_try(16'hABD7, 1'b0);
    // only lane 0 is strobed, so the upper base byte must survive
    host_u.xfer(1'b1, ADR_DMA_WIN, 32'h0000_55C4, 4'h1, d, e);
    chk("strobed write error flag", 32'h0, {31'h0, e});
    rd(ADR_DMA_WIN, 32'h0000_ABC4, "dma after strobed write");
    io_try(16'hABC7, 1'b0);
    $display("test dma window done");
  endtask

  task automatic t_pref();
    wr(ADR_PREFETCH, 32'h0000_0010);
    rd(ADR_PREFETCH, 32'h0000_0010, "prefetch writable bits");
    chk("prefetch off", 32'h1, {31'h0, pref_off});
    $display("test prefetch done");
  endtask

  task automatic t_err();
    int bitpos [4] = '{4, 3, 2, 2};
    logic [7:0] m;
    wr(ADR_SYSERR, 32'h0000_001C);
    rd(ADR_SYSERR, 32'h0000_001C, "error mask writable bits");
    for (int i = 0; i < 4; i++) begin
      m = 8'h1C & ~(8'h01 << bitpos[i]);
      wr(ADR_SYSERR, {24'h0, m});
      ev(i, 1'b0);
      wr(ADR_SYSERR, 32'h1 << bitpos[i]);
      ev(i, 1'b1);
    end
    $display("test error mask done");
  endtask

  task automatic t_unmapped();
    logic [31:0] d;
    logic        e;
    host_u.xfer(1'b0, 12'h264, 32'h0, 4'h0, d, e);
    chk("unmapped error flag", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, d);
    host_u.xfer(1'b1, 12'h268, 32'hFFFF_FFFF, 4'hF, d, e);
    chk("unmapped write error flag", 32'h1, {31'h0, e});
    rd(ADR_DMA_WIN, 32'h0000_ABC4, "dma after stray write");
    $display("test unmapped done");
  endtask

  // a reset in mid-run must clear every implemented bit again
  task automatic t_midreset();
    wr(ADR_DMA_WIN, 32'h0000_1235);
    wr(ADR_PREFETCH, 32'h0000_0010);
    wr(ADR_SYSERR, 32'h0000_001C);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    chk("base in reset", 32'h0, {20'h0, base});
    chk("xfer width in reset", 32'h0, {30'h0, xw});
    chk("decode on in reset", 32'h0, {31'h0, dec_on});
    chk("prefetch off in reset", 32'h0, {31'h0, pref_off});
    chk("syserr_n in reset", 32'h1, {31'h0, syserr_n});
    rd(ADR_DMA_WIN, 32'h0, "dma after mid reset");
    rd(ADR_PREFETCH, 32'h0, "prefetch after mid reset");
    rd(ADR_SYSERR, 32'h0, "mask after mid reset");
    ev(2, 1'b0);
    $display("test mid-run reset done");
  endtask

  // host leaves the unsupported features at their defaults
  task automatic t_restore();
    wr(ADR_DMA_WIN, 32'h0);
    wr(ADR_PREFETCH, 32'h0);
    rd(ADR_DMA_WIN, 32'h0, "dma restored");
    rd(ADR_PREFETCH, 32'h0, "prefetch restored");
    chk("prefetch on", 32'h0, {31'h0, pref_off});
    $display("test restore done");
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_dma();
    t_pref();
    t_err();
    t_unmapped();
    t_midreset();
    t_restore();
    tally_and_finish();
  end

  // the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge pclk);
    err_count++;
    tally_and_finish();
  end
endmodule
